//--- design/hsr_result_port.sv
/*
  Handler and scan result port: trigger input, grade pins, scan sequencing,
  AXI4-Lite registers and interrupt. Assumes a measurement engine on the same
  clock that answers each start with a conversion pulse and one result pulse.
*/
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "hsr_defs.svh"
module hsr_result_port (
  // Clock, enable, reset
  input wire logic clk,
  input wire logic ce,
  input wire logic nrst,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Connector
  input wire logic trig_pin,
  output logic [24:0] conn_pin,
  output logic irq,
  // Measurement engine
  output logic meas_start,
  output logic [6:0] meas_channel,
  input wire logic conv_done,
  input wire logic res_valid,
  input wire logic res_hi,
  input wire logic res_lo,
  input wire logic [3:0] res_bin,
  input wire logic user_cond_a,
  input wire logic user_cond_b
);
  import hsr_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;
  hsr_mode_t mode_q, run_mode_q;
  logic edge_fall_q, ext_en_q, lvl_a_q, lvl_b_q, sw_trig_q;
  logic [6:0] ch_cnt_q, ch_idx_q;
  logic [3:0] istat_q, imask_q, ev;
  hsr_state_t st_q;
  logic [7:0] cnt_q;
  logic trig_evt, busy, last_ch, pulse_end;
  logic fail_q, hi_q, lo_q, pass_q, bin_miss_q;
  logic [7:0] grade_slot_q;
  logic custom_logic_out_a_q, custom_logic_out_b_q;
  logic conversion_done_q, ready_q;
  logic relay_q, sc_pass_q, sc_lo_q, sc_hi_q, scan_clk_q, scan_complete_strobe_q;
  logic [24:0] conn_d;
  logic aw_held_q, w_held_q;
  logic [7:0] aw_addr_q, wr_addr;
  logic [31:0] w_data_q;
  logic wr_go;

  hsr_sync_if trig_s ();

  // Reset released through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  hsr_pin_sync u_trig_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin(trig_pin),
    .o(trig_s)
  );

  // Edge choice applies to the pin only; the software trigger is a plain pulse
  assign trig_evt = (ext_en_q && (edge_fall_q ? trig_s.fall : trig_s.rise))
                    || sw_trig_q;
  assign busy = (st_q != HSR_ST_IDLE);
  assign last_ch = (ch_idx_q == ch_cnt_q - 7'h01);
  assign pulse_end = (cnt_q == 8'(`HSR_PULSE_CYC - 1));

  // Write channel: address and data taken in either order
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_addr = aw_addr_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HSR_RESP_OK;
    end else if (ce) begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_addr == `HSR_A_CTRL || wr_addr == `HSR_A_SCAN ||
            wr_addr == `HSR_A_ISTAT || wr_addr == `HSR_A_IMASK) begin
          s_axi_bresp <= `HSR_RESP_OK;
        end else begin
          s_axi_bresp <= `HSR_RESP_ERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; low byte lane only carries fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= HSR_COMPARE;
      edge_fall_q <= 1'b0;
      ext_en_q <= 1'b1;
      lvl_a_q <= 1'b1;
      lvl_b_q <= 1'b1;
      sw_trig_q <= 1'b0;
      ch_cnt_q <= `HSR_CH_MAX;
      imask_q <= 4'h0;
    end else if (ce) begin
      sw_trig_q <= 1'b0;
      if (wr_go && s_axi_wstrb[0]) begin
        if (wr_addr == `HSR_A_CTRL) begin
          mode_q <= hsr_mode_t'(w_data_q[1:0]);
          edge_fall_q <= w_data_q[`HSR_C_EDGE];
          ext_en_q <= w_data_q[`HSR_C_EXT];
          lvl_a_q <= w_data_q[`HSR_C_LVLA];
          lvl_b_q <= w_data_q[`HSR_C_LVLB];
          sw_trig_q <= w_data_q[`HSR_C_SWTRIG];
        end else if (wr_addr == `HSR_A_SCAN) begin
          // Out-of-range counts clamp rather than fault
          if (w_data_q[7:0] < 8'(`HSR_CH_MIN)) begin
            ch_cnt_q <= `HSR_CH_MIN;
          end else if (w_data_q[7:0] > 8'(`HSR_CH_MAX)) begin
            ch_cnt_q <= `HSR_CH_MAX;
          end else begin
            ch_cnt_q <= w_data_q[6:0];
          end
        end else if (wr_addr == `HSR_A_IMASK) begin
          imask_q <= w_data_q[3:0];
        end
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear
  assign ev[`HSR_I_CONV] = (st_q == HSR_ST_MEAS) && conv_done;
  assign ev[`HSR_I_RES] = (st_q == HSR_ST_MEAS) && res_valid;
  assign ev[`HSR_I_SCAN] = (st_q == HSR_ST_SCAN_COMPLETE_STROBE) && pulse_end;
  assign ev[`HSR_I_OVR] = busy && trig_evt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      istat_q <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wr_go && s_axi_wstrb[0] && wr_addr == `HSR_A_ISTAT) begin
        istat_q <= (istat_q & ~w_data_q[3:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
      irq <= |(istat_q & imask_q);
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `HSR_RESP_OK;
    end else if (ce) begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `HSR_RESP_OK;
        if (s_axi_araddr == `HSR_A_CTRL) begin
          s_axi_rdata <= {26'h0, lvl_b_q, lvl_a_q, ext_en_q, edge_fall_q, mode_q};
        end else if (s_axi_araddr == `HSR_A_SCAN) begin
          s_axi_rdata <= {25'h0, ch_cnt_q};
        end else if (s_axi_araddr == `HSR_A_STAT) begin
          s_axi_rdata <= {16'h0, 1'b0, ch_idx_q, 2'h0, ready_q, conversion_done_q,
                          st_q, busy};
        end else if (s_axi_araddr == `HSR_A_ISTAT) begin
          s_axi_rdata <= {28'h0, istat_q};
        end else if (s_axi_araddr == `HSR_A_IMASK) begin
          s_axi_rdata <= {28'h0, imask_q};
        end else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `HSR_RESP_ERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Sequencer: single measurement, or a scan of ch_cnt_q channels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= HSR_ST_IDLE;
      run_mode_q <= HSR_COMPARE;
      ch_idx_q <= 7'h00;
      cnt_q <= 8'h00;
      meas_start <= 1'b0;
      meas_channel <= 7'h00;
      conversion_done_q <= 1'b0;
      ready_q <= 1'b0;
      relay_q <= 1'b0;
      scan_clk_q <= 1'b0;
      scan_complete_strobe_q <= 1'b0;
    end else if (ce) begin
      meas_start <= 1'b0;
      case (st_q)
        HSR_ST_IDLE: begin
          run_mode_q <= mode_q;
          ready_q <= ext_en_q;
          if (trig_evt && mode_q != HSR_NONE) begin
            // One trigger, one measurement or one scan of ch_cnt_q channels; triggers while busy are dropped
            st_q <= HSR_ST_MEAS;
            run_mode_q <= mode_q;
            ch_idx_q <= 7'h00;
            meas_channel <= 7'h00;
            meas_start <= 1'b1;
            ready_q <= 1'b0;
            conversion_done_q <= 1'b0;
            relay_q <= (mode_q == HSR_SCAN);
          end
        end
        HSR_ST_MEAS: begin
          if (conv_done) begin
            conversion_done_q <= ext_en_q;
          end
          if (res_valid) begin
            cnt_q <= 8'h00;
            if (run_mode_q == HSR_SCAN) begin
              st_q <= HSR_ST_SETUP;
            end else begin
              st_q <= HSR_ST_IDLE;
              ready_q <= ext_en_q;
            end
          end
        end
        HSR_ST_SETUP: begin
          cnt_q <= cnt_q + 8'h01;
          if (pulse_end) begin
            cnt_q <= 8'h00;
            st_q <= HSR_ST_CLK;
            scan_clk_q <= 1'b1;
          end
        end
        HSR_ST_CLK: begin
          cnt_q <= cnt_q + 8'h01;
          if (pulse_end) begin
            cnt_q <= 8'h00;
            scan_clk_q <= 1'b0;
            relay_q <= 1'b0;
            if (last_ch) begin
              st_q <= HSR_ST_SCAN_COMPLETE_STROBE;
              scan_complete_strobe_q <= 1'b1;
            end else begin
              st_q <= HSR_ST_MEAS;
              ch_idx_q <= ch_idx_q + 7'h01;
              meas_channel <= ch_idx_q + 7'h01;
              meas_start <= 1'b1;
              relay_q <= 1'b1;
            end
          end
        end
        HSR_ST_SCAN_COMPLETE_STROBE: begin
          cnt_q <= cnt_q + 8'h01;
          if (pulse_end) begin
            scan_complete_strobe_q <= 1'b0;
            st_q <= HSR_ST_IDLE;
            ready_q <= ext_en_q;
          end
        end
        default: begin
          st_q <= HSR_ST_IDLE;
        end
      endcase
    end
  end

  // Grades hold until the next result; a mode change clears stale ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {fail_q, hi_q, lo_q, pass_q, bin_miss_q} <= 5'h0;
      {sc_pass_q, sc_lo_q, sc_hi_q} <= 3'h0;
      grade_slot_q <= 8'h00;
      custom_logic_out_a_q <= 1'b0;
      custom_logic_out_b_q <= 1'b0;
    end else if (ce) begin
      if (st_q == HSR_ST_IDLE && mode_q != run_mode_q) begin
        {fail_q, hi_q, lo_q, pass_q, bin_miss_q} <= 5'h0;
        {sc_pass_q, sc_lo_q, sc_hi_q} <= 3'h0;
        grade_slot_q <= 8'h00;
      end else if (st_q == HSR_ST_MEAS && res_valid) begin
        custom_logic_out_a_q <= user_cond_a ? lvl_a_q : !lvl_a_q;
        custom_logic_out_b_q <= user_cond_b ? lvl_b_q : !lvl_b_q;
        if (run_mode_q == HSR_COMPARE) begin
          fail_q <= res_hi || res_lo;
          hi_q <= res_hi;
          lo_q <= res_lo && !res_hi;
          pass_q <= !res_hi && !res_lo;
        end else if (run_mode_q == HSR_BINNING) begin
          grade_slot_q <= 8'h00;
          if (res_bin >= 4'h1 && res_bin <= 4'h8) begin
            grade_slot_q[3'(res_bin - 4'h1)] <= 1'b1;
            bin_miss_q <= 1'b0;
          end else begin
            bin_miss_q <= 1'b1;
          end
        end else begin
          sc_hi_q <= res_hi;
          sc_lo_q <= res_lo && !res_hi;
          sc_pass_q <= !res_hi && !res_lo;
        end
      end
    end
  end

  // Pin functions follow the running mode; unused pins stay low
  always_comb begin
    conn_d = 25'h0;
    if (run_mode_q == HSR_SCAN) begin
      conn_d[`HSR_P_SC_HIGH-1] = sc_hi_q;
      conn_d[`HSR_P_SC_LOW-1] = sc_lo_q;
      conn_d[`HSR_P_SC_PASS-1] = sc_pass_q;
      conn_d[`HSR_P_SC_CLK-1] = scan_clk_q;
      conn_d[`HSR_P_SC_RELAY-1] = relay_q;
      conn_d[`HSR_P_SC_STROBE-1] = scan_complete_strobe_q;
    end else if (run_mode_q != HSR_NONE) begin
      conn_d[`HSR_P_CONV_DONE-1] = conversion_done_q;
      conn_d[`HSR_P_READY-1] = ready_q;
      conn_d[`HSR_P_USRA-1] = custom_logic_out_a_q;
      conn_d[`HSR_P_USRB-1] = custom_logic_out_b_q;
      if (run_mode_q == HSR_COMPARE) begin
        conn_d[`HSR_P_FAIL-1] = fail_q;
        conn_d[`HSR_P_HIGH-1] = hi_q;
        conn_d[`HSR_P_LOW-1] = lo_q;
        conn_d[`HSR_P_PASS-1] = pass_q;
      end else begin
        conn_d[`HSR_P_SLOT1-1] = grade_slot_q[0];
        conn_d[`HSR_P_SLOT2-1] = grade_slot_q[1];
        conn_d[`HSR_P_SLOT3-1] = grade_slot_q[2];
        conn_d[`HSR_P_SLOT4-1] = grade_slot_q[3];
        conn_d[`HSR_P_SLOT5-1] = grade_slot_q[4];
        conn_d[`HSR_P_SLOT6-1] = grade_slot_q[5];
        conn_d[`HSR_P_SLOT7-1] = grade_slot_q[6];
        conn_d[`HSR_P_SLOT8-1] = grade_slot_q[7];
        conn_d[`HSR_P_BINOUT-1] = bin_miss_q;
      end
    end
  end

  // Pins lag internal state by one cycle so every pin leaves a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conn_pin <= 25'h0;
    end else if (ce) begin
      conn_pin <= conn_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_result_cmp;
    ce && st_q == HSR_ST_MEAS && res_valid && run_mode_q == HSR_COMPARE;
  endsequence
  sequence s_last_clk_end;
    ce && st_q == HSR_ST_CLK && pulse_end && last_ch;
  endsequence

  a_start_on_trig: assert property ((ce && !busy && trig_evt && mode_q != HSR_NONE)
    |=> (meas_start && st_q == HSR_ST_MEAS)) else $error("no start on trigger");
  a_fail_grade: assert property (s_result_cmp |=> fail_q == $past(res_hi || res_lo))
    else $error("fail grade wrong");
  a_hi_lo_grade: assert property (s_result_cmp |=> (hi_q == $past(res_hi)
    && lo_q == $past(res_lo && !res_hi))) else $error("high or low wrong");
  a_pass_grade: assert property (s_result_cmp |=> pass_q == $past(!res_hi && !res_lo))
    else $error("pass grade wrong");
  a_eot_on_done: assert property ((ce && st_q == HSR_ST_MEAS && conv_done && ext_en_q)
    |=> conversion_done_q) else $error("conversion done missing");
  a_ready_idle: assert property (ready_q |-> !busy)
    else $error("ready while busy");
  a_bin_onehot: assert property ((ce && st_q == HSR_ST_MEAS && res_valid
    && run_mode_q == HSR_BINNING) |=> ($onehot0(grade_slot_q)
    && bin_miss_q != (|grade_slot_q))) else $error("bin grade wrong");
  a_ch_range: assert property (ch_cnt_q >= `HSR_CH_MIN && ch_cnt_q <= `HSR_CH_MAX)
    else $error("channel count out of range");
  a_clk_relay: assert property ($rose(scan_clk_q) |-> (relay_q && run_mode_q == HSR_SCAN))
    else $error("scan clock without relay");
  a_strobe_last: assert property (s_last_clk_end |=> (scan_complete_strobe_q
    && !scan_clk_q)) else $error("strobe not after last group");
  a_pins_mode: assert property ((ce && run_mode_q == HSR_SCAN)
    |=> conn_pin[`HSR_P_BINOUT-1] == 1'b0) else $error("handler pin in scan");
endmodule : hsr_result_port

//--- design/hsr_defs.svh
/*
  Offsets, field positions, reset values, pin positions and timing counts
  for the handler and scan result port. Assumes a 25 MHz clock.
*/
`ifndef HSR_DEFS_SVH
`define HSR_DEFS_SVH
`define HSR_A_CTRL 8'h00
`define HSR_A_SCAN 8'h04
`define HSR_A_STAT 8'h08
`define HSR_A_ISTAT 8'h0c
`define HSR_A_IMASK 8'h10
`define HSR_C_EDGE 2
`define HSR_C_EXT 3
`define HSR_C_LVLA 4
`define HSR_C_LVLB 5
`define HSR_C_SWTRIG 7
`define HSR_CTRL_RST 8'h38
`define HSR_CH_MIN 7'h01
`define HSR_CH_MAX 7'h64
`define HSR_I_CONV 0
`define HSR_I_RES 1
`define HSR_I_SCAN 2
`define HSR_I_OVR 3
`define HSR_RESP_OK 2'h0
`define HSR_RESP_ERR 2'h2
`define HSR_CLK_NS 40
`define HSR_PULSE_NS 1000
`define HSR_PULSE_CYC ((`HSR_PULSE_NS + `HSR_CLK_NS - 1) / `HSR_CLK_NS)
`define HSR_P_FAIL 4
`define HSR_P_HIGH 5
`define HSR_P_PASS 6
`define HSR_P_CONV_DONE 7
`define HSR_P_SLOT1 9
`define HSR_P_SLOT2 10
`define HSR_P_SLOT3 11
`define HSR_P_SLOT4 12
`define HSR_P_SLOT5 13
`define HSR_P_USRB 15
`define HSR_P_USRA 16
`define HSR_P_READY 20
`define HSR_P_SLOT6 21
`define HSR_P_LOW 22
`define HSR_P_SLOT7 23
`define HSR_P_SLOT8 24
`define HSR_P_BINOUT 25
`define HSR_P_SC_HIGH 4
`define HSR_P_SC_CLK 5
`define HSR_P_SC_LOW 6
`define HSR_P_SC_PASS 7
`define HSR_P_SC_RELAY 20
`define HSR_P_SC_STROBE 22
`endif

//--- design/hsr_pkg.sv
/*
  Types of the handler and scan result port.
  Assumes hsr_defs.svh for all numeric constants.
*/
package hsr_pkg;
  typedef enum logic [1:0] {
    HSR_COMPARE = 2'b00,
    HSR_BINNING = 2'b01,
    HSR_SCAN = 2'b10,
    HSR_NONE = 2'b11
  } hsr_mode_t;
  typedef enum logic [2:0] {
    HSR_ST_IDLE = 3'b000,
    HSR_ST_MEAS = 3'b001,
    HSR_ST_SETUP = 3'b010,
    HSR_ST_CLK = 3'b011,
    HSR_ST_SCAN_COMPLETE_STROBE = 3'b100
  } hsr_state_t;
endpackage : hsr_pkg

//--- design/hsr_sync_if.sv
/*
  Carries a synchronised pin level and its edge pulses between modules.
  Assumes one clock on both sides.
*/
`timescale 1ns/1ps
interface hsr_sync_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : hsr_sync_if

//--- design/hsr_pin_sync.sv
/*
  Three-stage pin synchroniser with agreement filter and edge pulses.
  Assumes an asynchronous pin and an already synchronised reset.
*/
`timescale 1ns/1ps
module hsr_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pin and result
  input wire logic pin,
  hsr_sync_if.src o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lv_q;
  logic rise_q;
  logic fall_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lv_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else if (ce) begin
      rise_q <= (s2_q == s3_q) && s3_q && !lv_q;
      fall_q <= (s2_q == s3_q) && !s3_q && lv_q;
      if (s2_q == s3_q) begin
        lv_q <= s3_q;
      end
    end
  end

  assign o.level = lv_q;
  assign o.rise = rise_q;
  assign o.fall = fall_q;
endmodule : hsr_pin_sync

//--- sim/hsr_engine_model.sv
/* Measurement engine model: answers each start after a delay.
   Assumes the port's clock; result fields invert every cycle while idle. */
`timescale 1ns/1ps
module hsr_engine_model (
  // Clock and request
  input wire logic clk,
  input wire logic meas_start,
  // Result to deliver
  input wire logic [5:0] dly,
  input wire logic [7:0] res,
  // Answer
  output logic conv_done,
  output logic res_valid,
  output logic [7:0] fld
);
  logic [5:0] cnt_q = 6'h00;
  logic done_q = 1'b0;
  logic valid_q = 1'b0;
  logic [7:0] fld_q = 8'h00;
  assign conv_done = done_q;
  assign res_valid = valid_q;
  assign fld = fld_q;
  always @(posedge clk) begin
    done_q <= 1'b0;
    valid_q <= 1'b0;
    fld_q <= ~fld_q; // Fields mean nothing outside the pulse
    if (meas_start) cnt_q <= dly;
    else if (cnt_q == 6'h01) begin
      done_q <= 1'b1;
      valid_q <= 1'b1;
      fld_q <= res;
      cnt_q <= 6'h00;
    end else if (cnt_q != 6'h00) cnt_q <= cnt_q - 6'h01;
  end
endmodule : hsr_engine_model

//--- sim/handler_scan_result_port_tb_top.sv
/* Self-checking bench of the result port with an engine model.
   Assumes 25 MHz clock; ready on pin 20 marks the end of a measurement. */
`timescale 1ns/1ps
module handler_scan_result_port_tb_top;
  logic clk, awr, wrdy, bv, arr, rv, irq, ms, cd, rvd, prv_c, prv_s;
  logic nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, trig = 0, scan_on = 0;
  logic [7:0] awa = 0, ara = 0, res = 0, fld, r;
  logic [31:0] wd = 0, rdat;
  logic [1:0] bresp, rresp;
  logic [24:0] pins;
  logic [5:0] dly = 6'h01;
  logic [2:0] sexp;
  int miscompares, comparisons, nst, cyc, nclk, nstb, early, n0;
  int slot[8] = '{8, 9, 10, 11, 12, 20, 22, 23};

  hsr_result_port dut (.clk(clk), .ce(1'b1), .nrst(nrst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .trig_pin(trig), .conn_pin(pins), .irq(irq), .meas_start(ms), .meas_channel(),
    .conv_done(cd), .res_valid(rvd), .res_hi(fld[5]), .res_lo(fld[4]),
    .res_bin(fld[3:0]), .user_cond_a(fld[6]), .user_cond_b(fld[7]));
  hsr_engine_model eng (.clk(clk), .meas_start(ms), .dly(dly), .res(res),
    .conv_done(cd), .res_valid(rvd), .fld(fld));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task finish_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bv);
    chk(bresp, er);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    chk(rresp, er);
    chk(rdat, ed);
  endtask : rd

  // Handler side: one pulse held eight cycles, then wait for the start it caused
  task pulse;
    n0 = nst;
    trig <= 1'b1;
    repeat (8) @(posedge clk);
    early = nst - n0;
    trig <= 1'b0;
    repeat (8) @(posedge clk);
    while (nst == n0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask : pulse

  function automatic logic [31:0] exp_pins(input int m, input logic [7:0] v);
    logic [31:0] p;
    p = 32'h00080040;
    if (m == 0) begin
      p[3] = v[5] | v[4];
      p[4] = v[5];
      p[21] = v[4] & ~v[5];
      p[5] = ~(v[5] | v[4]);
    end else if (v[3:0] >= 1 && v[3:0] <= 8) p[slot[v[3:0] - 1]] = 1'b1;
    else p[24] = 1'b1;
    return p;
  endfunction : exp_pins

  task meas(input int m, input int fe, input logic [7:0] v);
    res <= v;
    dly <= 6'($urandom_range(40, 1));
    @(posedge clk);
    pulse();
    while (pins[19] !== 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
    chk(32'(early), fe ? 0 : 1);
    chk(32'(nst - n0), 1);
    chk(32'(pins) & 32'h1ff3fff, exp_pins(m, v));
  endtask : meas

  always @(posedge clk) begin
    cyc++;
    if (ms) nst++;
    prv_c <= pins[4];
    prv_s <= pins[21];
    if (scan_on && pins[4] && !prv_c) begin
      nclk++;
      chk({pins[19], pins[6], pins[5], pins[3]}, {1'b1, sexp});
    end
    if (scan_on && pins[21] && !prv_s) nstb++;
    if (cyc == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    void'($urandom(32'h3b1f));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h00, 32'h38, 2'h0);
    rd(8'h04, 32'h64, 2'h0);
    rd(8'h10, 32'h00, 2'h0);
    rd(8'h40, 32'h00, 2'h2);
    wr(8'h40, 32'h01, 2'h2);
    chk(pins[19], 1'b1);
    meas(0, 0, 8'($urandom));
    chk(irq, 1'b0);
    wr(8'h0c, 32'h03, 2'h0);
    wr(8'h10, 32'h02, 2'h0);
    for (int i = 0; i < 6; i++) meas(0, 0, 8'($urandom));
    chk(irq, 1'b1);
    rd(8'h0c, 32'h03, 2'h0);
    wr(8'h0c, 32'h03, 2'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(8'h00, 32'h0c, 2'h0);
    meas(0, 1, 8'($urandom) | 8'hc0);
    chk({pins[15], pins[14]}, 2'b00);
    wr(8'h00, 32'h38, 2'h0);
    meas(0, 0, 8'($urandom) | 8'hc0);
    chk({pins[15], pins[14]}, 2'b11);
    meas(0, 0, 8'($urandom) & 8'h3f);
    chk({pins[15], pins[14]}, 2'b00);
    wr(8'h00, 32'h09, 2'h0);
    for (int b = 0; b < 10; b++) meas(1, 0, {4'($urandom), 4'(b)});
    wr(8'h00, 32'h0b, 2'h0);
    repeat (3) @(posedge clk);
    chk(32'(pins), 32'h0);
    wr(8'h04, 32'h00, 2'h0);
    rd(8'h04, 32'h01, 2'h0);
    wr(8'h04, 32'hc8, 2'h0);
    rd(8'h04, 32'h64, 2'h0);
    wr(8'h00, 32'h0a, 2'h0);
    repeat (3) @(posedge clk);
    scan_on = 1'b1;
    for (int c = 1; c <= 3; c++) begin
      wr(8'h04, 32'(c), 2'h0);
      r = 8'($urandom);
      res <= r;
      dly <= 6'($urandom_range(40, 1));
      sexp = {~(r[5] | r[4]), r[4] & ~r[5], r[5]};
      nclk = 0;
      nstb = 0;
      pulse();
      while (pins[21] !== 1'b1) @(posedge clk);
      while (pins[21] === 1'b1) @(posedge clk);
      repeat (3) @(posedge clk);
      chk(32'(nclk), 32'(c));
      chk(32'(nstb), 1);
      chk(32'(nst - n0), 32'(c));
      chk(pins[19], 1'b0);
    end
    finish_test();
  end
endmodule : handler_scan_result_port_tb_top
